// ---- core/arf_framer.sv ----
// result framer, gpio and reset sequencing
//
// What this block does
// - temp mode ignores configuration 0 and forces the internal reference
// - temperature conversions use the normal start and readout commands
// - temperature is 14 bits left-justified in the 16-bit word
// - one count equals 0.03125 degrees Celsius
// - negative temperatures are two's complement, top bit set
// - serialised bytes go out least significant bit first
// - counter enabled puts an 8-bit count before each result read
// - counter starts at 00h, increments per conversion, wraps at FFh
// - counter clears on disable-then-enable and on any reset
// - integrity applies to register and result reads, counter included
// - integrity mode 01 sends an inverted copy after the data
// - integrity mode 10 sends a 16-bit checksum after the data
// - checksum is CCITT x16+x12+x5+1 remainder, preset all ones
// - each of three pins has its own direction bit
// - pin data reads back written value as input and pin level as output, drives written value as output
// - third pin as output carries ready strobe when route select set
// - power-on, reset pin and reset command each reset immediately
// - any reset restores defaults and idles until start command
// - power-on reset releases about 600 us after supplies are good
// - sleep command lets an ongoing conversion finish first
// - ready strobe falls on a new result, rises on the read data command
// - reset command is 06h or 07h, host waits the reset delay
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module arf_framer
  import arf_pkg::*;
#(
  parameter int POR_COUNT = POR_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic supplyGood,
  input wire logic resetPinN,
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire logic convDone,
  input wire logic [15:0] convData,
  output logic convStart,
  output logic useIntRef,
  output logic cfg0Bypass,
  input wire logic [2:0] gpioIn,
  output logic [2:0] gpioOut,
  output logic [2:0] gpioOe,
  output logic txValid,
  output logic [7:0] txByte,
  input wire logic txReady,
  output logic resultReadyN,
  output logic lowPower,
  output logic [2:0] txBitOrder
);

  ////////////////////////////////////////////////////////////////////////
  // reset sources
  logic supplySync0, supplySync1, pinSync0, pinSync1;
  logic [2:0] gpioSync0, gpioSync1;
  logic [19:0] porCnt;
  logic porActive;
  logic cmdReset;
  logic [7:0] rstCmdCnt;
  logic devRst;

  always_ff @(posedge clk) begin
    supplySync0 <= supplyGood;
    supplySync1 <= supplySync0;
    pinSync0 <= resetPinN;
    pinSync1 <= pinSync0;
    gpioSync0 <= gpioIn;
    gpioSync1 <= gpioSync0;
  end

  always_ff @(posedge clk) begin
    if (!nrst || !supplySync1) begin
      porCnt <= 20'h00000;
      porActive <= 1'b1;
    end else if (porActive) begin
      porCnt <= porCnt + 20'h00001;
      porActive <= (porCnt < 20'(POR_COUNT - 1));
    end
  end

  assign devRst = porActive || !pinSync1 || cmdReset;

  always_ff @(posedge clk) begin
    if (devRst) begin
      rstCmdCnt <= 8'(RST_CMD_CYCLES);
    end else if (rstCmdCnt != 8'h00) begin
      rstCmdCnt <= rstCmdCnt - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [5:0] ctrl;
  logic [2:0] pinDir, pinDat;
  logic [15:0] resultWord;
  logic [7:0] convCount;
  logic sleepPending, converting, running, resultNew;
  logic wrCtrl, wrCmd, wrGpio, rdResult, rdRegCmd;
  logic [7:0] cmdByte;
  logic cmdIsReset;
  logic busy;

  assign busy = txValid || cmdReset;
  // reads take one wait state so the registered data stand when accepted
  logic rdPhase;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdPhase <= 1'b0;
    end else begin
      rdPhase <= avsRead && !busy && !rdPhase;
    end
  end
  assign avsWaitRequest = ((avsRead || avsWrite) && busy) || (avsRead && !rdPhase);
  assign wrCtrl = avsWrite && !busy && avsAddress == ADDR_CTRL;
  assign wrCmd = avsWrite && !busy && avsAddress == ADDR_CMD;
  assign wrGpio = avsWrite && !busy && avsAddress == ADDR_GPIO;
  assign cmdByte = avsWriteData[7:0];
  assign cmdIsReset = cmdByte == CMD_RESET_A || cmdByte == CMD_RESET_B;
  assign rdResult = wrCmd && cmdByte == CMD_RDATA;
  assign rdRegCmd = wrCmd && cmdByte == CMD_RREG;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmdReset <= 1'b0;
    end else begin
      cmdReset <= wrCmd && cmdIsReset;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || devRst) begin
      ctrl <= CTRL_RESET;
      pinDir <= GPIO_DIR_RESET;
      pinDat <= GPIO_DAT_RESET;
    end else begin
      if (wrCtrl) begin
        ctrl <= avsWriteData[5:0];
      end
      if (wrGpio) begin
        pinDir <= avsWriteData[GPIO_DIR +: 3];
        pinDat <= avsWriteData[GPIO_DAT +: 3];
      end
    end
  end

  assign useIntRef = ctrl[CTRL_TEMP];
  assign cfg0Bypass = ctrl[CTRL_TEMP];

  ////////////////////////////////////////////////////////////////////////
  // conversion control and counter
  logic cntDisable;
  assign cntDisable = wrCtrl && !avsWriteData[CTRL_CNT];

  always_ff @(posedge clk) begin
    if (!nrst || devRst) begin
      running <= 1'b0;
      converting <= 1'b0;
      sleepPending <= 1'b0;
      convCount <= CNT_RESET;
      resultWord <= 16'h0000;
      resultNew <= 1'b0;
    end else begin
      if (wrCmd && cmdByte == CMD_START) begin
        running <= 1'b1;
        converting <= 1'b1;
        sleepPending <= 1'b0;
      end else if (wrCmd && cmdByte == CMD_SLEEP) begin
        sleepPending <= converting;
        running <= converting;
      end else if (convDone && converting) begin
        converting <= ctrl[CTRL_CONV] && !sleepPending;
        running <= ctrl[CTRL_CONV] && !sleepPending;
        sleepPending <= 1'b0;
      end
      if (cntDisable) begin
        convCount <= CNT_RESET;
      end else if (convDone && converting) begin
        convCount <= convCount + 8'h01;
      end
      if (convDone && converting) begin
        resultWord <= ctrl[CTRL_TEMP] ? {convData[15:2], 2'b00} : convData;
        resultNew <= 1'b1;
      end else if (rdResult) begin
        resultNew <= 1'b0;
      end
    end
  end

  assign convStart = wrCmd && cmdByte == CMD_START;
  assign lowPower = !running;
  assign resultReadyN = !resultNew;

  ////////////////////////////////////////////////////////////////////////
  // gpio
  assign gpioOe = ~pinDir;
  assign gpioOut = {ctrl[CTRL_ROUTE] ? resultReadyN : pinDat[2], pinDat[1:0]};

  ////////////////////////////////////////////////////////////////////////
  // frame sequencer
  logic [7:0] frame [0:5];
  logic [2:0] frameLen, frameIdx;
  logic [15:0] crc;
  logic [15:0] dataWord;
  logic withCnt;
  logic [1:0] integ;

  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ b[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  assign withCnt = rdResult && ctrl[CTRL_CNT];
  assign integ = ctrl[CTRL_INTEG +: 2];
  assign dataWord = rdResult ? resultWord : {10'h000, ctrl};

  logic [15:0] crcFull, crcData;
  assign crcData = crcByte(crcByte(CRC_INIT, dataWord[7:0]), dataWord[15:8]);
  assign crcFull = withCnt ? crcByte(crcByte(crcByte(CRC_INIT, convCount),
                                     dataWord[7:0]), dataWord[15:8]) : crcData;

  always_ff @(posedge clk) begin
    if (!nrst || devRst) begin
      txValid <= 1'b0;
      frameIdx <= 3'h0;
      frameLen <= 3'h0;
      txByte <= 8'h00;
      crc <= CRC_INIT;
      for (int i = 0; i < 6; i++) begin
        frame[i] <= 8'h00;
      end
    end else if (!txValid && (rdResult || rdRegCmd)) begin
      crc <= crcFull;
      txValid <= 1'b1;
      frameIdx <= 3'h1;
      if (withCnt) begin
        frame[0] <= convCount;
        frame[1] <= dataWord[7:0];
        frame[2] <= dataWord[15:8];
        frame[3] <= (integ == INTEG_INV) ? ~convCount : crcFull[7:0];
        frame[4] <= (integ == INTEG_INV) ? ~dataWord[7:0] : crcFull[15:8];
        frame[5] <= ~dataWord[15:8];
        frameLen <= (integ == INTEG_NONE) ? 3'h3 : (integ == INTEG_INV) ? 3'h6 : 3'h5;
      end else begin
        frame[0] <= dataWord[7:0];
        frame[1] <= dataWord[15:8];
        frame[2] <= (integ == INTEG_INV) ? ~dataWord[7:0] : crcFull[7:0];
        frame[3] <= (integ == INTEG_INV) ? ~dataWord[15:8] : crcFull[15:8];
        frame[4] <= 8'h00;
        frame[5] <= 8'h00;
        frameLen <= (integ == INTEG_NONE) ? 3'h2 : 3'h4;
      end
      txByte <= withCnt ? convCount : dataWord[7:0];
    end else if (txValid && txReady) begin
      if (frameIdx == frameLen) begin
        txValid <= 1'b0;
      end else begin
        txByte <= frame[frameIdx];
        frameIdx <= frameIdx + 3'h1;
      end
    end
  end

  assign txBitOrder = 3'h0;

  ////////////////////////////////////////////////////////////////////////
  // register readback
  logic [31:0] rdMux;
  assign rdMux = (avsAddress == ADDR_CTRL) ? {26'h0, ctrl} :
                 (avsAddress == ADDR_GPIO) ?
                   {25'h0, (pinDir & pinDat) | (~pinDir & gpioSync1), 1'b0, pinDir} :
                 (avsAddress == ADDR_RESULT) ? {16'h0, resultWord} :
                 (avsAddress == ADDR_STATUS) ?
                   {20'h0, convCount, sleepPending, running, resultNew, txValid} :
                 (avsAddress == ADDR_TXBYTE) ? {24'h0, txByte} :
                 (avsAddress == ADDR_RDREG) ? {31'h0, rstCmdCnt != 8'h00} :
                 32'h00000000;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      avsReadData <= 32'h00000000;
    end else if (avsRead && !busy && !rdPhase) begin
      avsReadData <= rdMux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  cnt_wrap_a: assert property (@(posedge clk) disable iff (!nrst || devRst)
    (convDone && converting && !cntDisable) |=> convCount == $past(convCount) + 8'h01)
    else $error("counter did not step");
  cnt_clear_a: assert property (@(posedge clk) disable iff (!nrst || devRst)
    cntDisable |=> convCount == CNT_RESET)
    else $error("counter not cleared");
  strobe_fall_a: assert property (@(posedge clk) disable iff (!nrst || devRst)
    (convDone && converting) |=> !resultReadyN)
    else $error("ready strobe not low");
  strobe_rise_a: assert property (@(posedge clk) disable iff (!nrst || devRst)
    (rdResult && !(convDone && converting)) |=> resultReadyN)
    else $error("ready strobe not high");
  pin_route_a: assert property (@(posedge clk) disable iff (!nrst)
    ctrl[CTRL_ROUTE] |-> gpioOut[2] == resultReadyN)
    else $error("strobe not routed");
  temp_ref_a: assert property (@(posedge clk) disable iff (!nrst)
    ctrl[CTRL_TEMP] |-> useIntRef && cfg0Bypass)
    else $error("temp mode ref wrong");
  temp_just_a: assert property (@(posedge clk) disable iff (!nrst || devRst)
    (convDone && converting && ctrl[CTRL_TEMP]) |=> resultWord[1:0] == 2'b00)
    else $error("temp not left justified");
  sleep_wait_a: assert property (@(posedge clk) disable iff (!nrst || devRst)
    (wrCmd && cmdByte == CMD_SLEEP && converting) |=> running)
    else $error("sleep cut conversion");
  cmd_reset_a: assert property (@(posedge clk) disable iff (!nrst)
    (wrCmd && cmdIsReset) |=> ##2 ctrl == CTRL_RESET && !running)
    else $error("reset command ignored");
  frame_len_a: assert property (@(posedge clk) disable iff (!nrst || devRst)
    (!txValid && rdResult && ctrl[CTRL_CNT] && integ == INTEG_INV) |=> frameLen == 3'h6)
    else $error("inverted frame length");
  inv_copy_a: assert property (@(posedge clk) disable iff (!nrst || devRst)
    (!txValid && rdResult && ctrl[CTRL_CNT] && integ == INTEG_INV)
    |=> frame[3] == ~$past(convCount) && frame[5] == ~$past(dataWord[15:8]))
    else $error("inverted counter copy wrong");
  inv_data_a: assert property (@(posedge clk) disable iff (!nrst || devRst)
    (!txValid && rdResult && ctrl[CTRL_CNT] && integ == INTEG_INV)
    |=> frame[4] == ~$past(dataWord[7:0]))
    else $error("inverted data copy wrong");
  crc_len_a: assert property (@(posedge clk) disable iff (!nrst || devRst)
    (!txValid && rdRegCmd && integ == INTEG_CRC) |=> frameLen == 3'h4)
    else $error("checksum frame length");

endmodule
`default_nettype wire

// ---- core/arf_pkg.sv ----
// constants and register map of the result framer
package arf_pkg;
  localparam int CLK_MHZ = 125;
  localparam int POR_US = 600;
  localparam int POR_CYCLES = POR_US * CLK_MHZ;
  localparam int RST_CMD_NS = 1000;
  localparam int RST_CMD_CYCLES = (RST_CMD_NS * CLK_MHZ + 999) / 1000;
  // register word addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CMD = 4'h1;
  localparam logic [3:0] ADDR_GPIO = 4'h2;
  localparam logic [3:0] ADDR_RESULT = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_TXBYTE = 4'h5;
  localparam logic [3:0] ADDR_RDREG = 4'h6;
  // ctrl field positions
  localparam int CTRL_TEMP = 0;
  localparam int CTRL_CNT = 1;
  localparam int CTRL_INTEG = 2;
  localparam int CTRL_CONV = 4;
  localparam int CTRL_ROUTE = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  // gpio field positions: dir [2:0], data [6:4]
  localparam int GPIO_DIR = 0;
  localparam int GPIO_DAT = 4;
  localparam logic [2:0] GPIO_DIR_RESET = 3'h0;
  localparam logic [2:0] GPIO_DAT_RESET = 3'h0;
  // integrity modes
  localparam logic [1:0] INTEG_NONE = 2'h0;
  localparam logic [1:0] INTEG_INV = 2'h1;
  localparam logic [1:0] INTEG_CRC = 2'h2;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [7:0] CNT_RESET = 8'h00;
  // command bytes
  localparam logic [7:0] CMD_RESET_A = 8'h06;
  localparam logic [7:0] CMD_RESET_B = 8'h07;
  localparam logic [7:0] CMD_START = 8'h08;
  localparam logic [7:0] CMD_SLEEP = 8'h02;
  localparam logic [7:0] CMD_RDATA = 8'h10;
  localparam logic [7:0] CMD_RREG = 8'h20;
  localparam int TEMP_BITS = 14;
  localparam int WORD_BITS = 16;
endpackage

// ---- tb/arf_host_model.sv ----
// host side model: takes framed bytes from the stream port
`timescale 1ns/1ns
`default_nettype none
module arf_host_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic txValid,
  input wire logic [7:0] txByte,
  output logic txReady
);
  logic [7:0] rxq[$];
  // stalls every other cycle when slow
  always @(posedge clk) begin
    if (!nrst) begin
      txReady <= 1'b0;
    end else begin
      txReady <= slow ? !txReady : 1'b1;
      if (txValid && txReady) begin
        rxq.push_back(txByte);
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the result framer
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import arf_pkg::*;
  localparam int PORC = 20;
  logic clk = 1'b0, nrst = 1'b0, supplyGood = 1'b1, resetPinN = 1'b1;
  logic [3:0] avsAddress = 4'h0;
  logic avsRead = 1'b0, avsWrite = 1'b0, convDone = 1'b0, slow = 1'b0;
  logic [31:0] avsWriteData = 32'h0, avsReadData, q;
  logic avsWaitRequest, convStart, useIntRef, cfg0Bypass;
  logic [15:0] convData = 16'h0;
  logic [2:0] gpioIn = 3'h2;
  logic [2:0] gpioOut, gpioOe, txBitOrder;
  logic txValid, txReady, resultReadyN, lowPower;
  logic [7:0] txByte;
  logic [7:0] ex[$];
  int failures = 0, cmp_count = 0;
  arf_framer #(.POR_COUNT(PORC)) dut (.clk, .nrst, .supplyGood, .resetPinN, .avsAddress,
    .avsRead, .avsWrite, .avsWriteData, .avsReadData, .avsWaitRequest, .convDone, .convData,
    .convStart, .useIntRef, .cfg0Bypass, .gpioIn, .gpioOut, .gpioOe, .txValid, .txByte,
    .txReady, .resultReadyN, .lowPower, .txBitOrder);
  arf_host_model host (.clk, .nrst, .slow, .txValid, .txByte, .txReady);
  initial forever #4 clk = !clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (failures == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    logic w;
    n = 0;
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWriteData <= d;
    do begin
      @(posedge clk);
      w = avsWaitRequest;
      n++;
    end while (w !== 1'b0 && n < 5000);
    q = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    if (w !== 1'b0) begin
      failures++;
      results();
    end
    @(posedge clk);
  endtask
  task automatic conv(input logic [15:0] d);
    convData <= d;
    convDone <= 1'b1;
    @(posedge clk);
    convDone <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] r;
    r = CRC_INIT;
    foreach (b[i])
      for (int k = 7; k >= 0; k--)
        r = {r[14:0], 1'b0} ^ ((r[15] ^ b[i][k]) ? CRC_POLY : 16'h0);
    return r;
  endfunction
  task automatic addcrc();
    logic [15:0] r;
    r = crc(ex);
    ex.push_back(r[7:0]);
    ex.push_back(r[15:8]);
  endtask
  task automatic frame(input logic [7:0] c);
    int n;
    n = 0;
    bus(1'b1, ADDR_CMD, {24'h0, c});
    while (host.rxq.size() < ex.size() && n < 500) begin
      @(posedge clk);
      n++;
    end
    if (n >= 500) begin
      failures++;
      results();
    end
    repeat (4) @(posedge clk);
    chk(host.rxq.size(), ex.size());
    foreach (ex[i])
      if (i < host.rxq.size())
        chk(host.rxq[i], ex[i]);
    host.rxq.delete();
    ex.delete();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    results();
  end
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (PORC + 4) @(posedge clk);
    chk(lowPower, 1'b1);
    chk(resultReadyN, 1'b1);
    chk(txBitOrder, 3'h0);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 4'hF, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, ADDR_GPIO, 32'h35);
    chk(gpioOe, 3'b010);
    chk(gpioOut & 3'b101, 3'b001);
    bus(1'b0, ADDR_GPIO, 32'h0);
    chk({q[6:4], q[2:0]}, 6'h1D);
    bus(1'b1, ADDR_CTRL, 32'h33);
    chk({useIntRef, cfg0Bypass}, 2'b11);
    chk(gpioOut[2], 1'b1);
    bus(1'b1, ADDR_CMD, {24'h0, CMD_START});
    chk(lowPower, 1'b0);
    slow <= 1'b1;
    conv(16'hF380);
    chk(resultReadyN, 1'b0);
    chk(gpioOut[2], resultReadyN);
    ex = '{8'h01, 8'h80, 8'hF3};
    frame(CMD_RDATA);
    chk(resultReadyN, 1'b1);
    bus(1'b1, ADDR_CTRL, 32'h3B);
    conv(16'h2580);
    ex = '{8'h02, 8'h80, 8'h25};
    addcrc();
    frame(CMD_RDATA);
    bus(1'b1, ADDR_CTRL, 32'h37);
    conv(16'h0020);
    ex = '{8'h03, 8'h20, 8'h00, 8'hFC, 8'hDF, 8'hFF};
    frame(CMD_RDATA);
    repeat (253) conv(16'h0020);
    ex = '{8'h00, 8'h20, 8'h00, 8'hFF, 8'hDF, 8'hFF};
    frame(CMD_RDATA);
    bus(1'b1, ADDR_CTRL, 32'h35);
    bus(1'b1, ADDR_CTRL, 32'h37);
    conv(16'h0020);
    ex = '{8'h01, 8'h20, 8'h00, 8'hFE, 8'hDF, 8'hFF};
    frame(CMD_RDATA);
    bus(1'b1, ADDR_CTRL, 32'h3A);
    ex = '{8'h3A, 8'h00};
    addcrc();
    frame(CMD_RREG);
    bus(1'b1, ADDR_CMD, {24'h0, CMD_SLEEP});
    chk(lowPower, 1'b0);
    conv(16'h0020);
    repeat (2) @(posedge clk);
    chk(lowPower, 1'b1);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, ADDR_CTRL, 32'h37);
      bus(1'b1, ADDR_CMD, {24'h0, i ? CMD_RESET_B : CMD_RESET_A});
      repeat (RST_CMD_CYCLES) @(posedge clk);
      bus(1'b0, ADDR_CTRL, 32'h0);
      chk(q, 32'h0);
    end
    bus(1'b1, ADDR_CTRL, 32'h37);
    resetPinN <= 1'b0;
    repeat (3) @(posedge clk);
    resetPinN <= 1'b1;
    repeat (PORC + 4) @(posedge clk);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h37);
    supplyGood <= 1'b0;
    repeat (3) @(posedge clk);
    supplyGood <= 1'b1;
    repeat (PORC + 4) @(posedge clk);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(q, 32'h0);
    chk(lowPower, 1'b1);
    results();
  end
endmodule
`default_nettype wire
